// *** inc/smr_pkg.sv ***
// Constants shared by both ends of the register access link.
// Assumes a 125 MHz host clock and an 8 MHz device link clock.
// Operation
// R01 - Slave answers 7-bit address plus direction
// R02 - Enable strap high selects address 0x2E
// R03 - Enable low: level picks 0x2C or 0x2D
// R04 - Address frozen at first matching address byte
// R05 - Nine clocks per byte, receiver acknowledges
// R06 - SDA changes only while SCL low
// R07 - Master NACKs read, then forms stop
// R08 - Writes take one or two bytes, reads one
// R09 - First written byte loads address pointer
// R10 - Second written byte goes to pointed register
// R11 - Read returns pointed register, pointer kept
// R12 - Send, receive and read byte supported
// R13 - Repeated start begins a new operation
// R14 - Register space holds two 256-byte pages
// R15 - Page select is pointer's top bit; code takes it from bit 0 written to 0xFF
// R16 - Idle bus for 25 ms releases SDA
// R17 - Timeout disable is bit 4 of 0x11
// R18 - Pointer never auto-increments
package smr_pkg;
  localparam logic [6:0] ADDR_DEFAULT = 7'h2E;
  localparam logic [6:0] ADDR_SEL_LO = 7'h2C;
  localparam logic [6:0] ADDR_SEL_HI = 7'h2D;
  localparam int REG_AW = 9;
  localparam logic [7:0] PAGE_REG = 8'hFF;
  localparam int PAGE_BIT = 0;
  localparam logic [8:0] TOCFG_REG = 9'h011;
  localparam int BUS_TIMEOUT_DISABLE_BIT = 4;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic PAGE_RST = 1'b0;
  localparam logic BUS_TIMEOUT_DISABLE_RST = 1'b0;
  localparam int TIMEOUT_MS = 25;
  localparam int LINK_CLK_NS = 125;
  localparam int TIMEOUT_CYC =
    (TIMEOUT_MS * 1000000 + LINK_CLK_NS - 1) / LINK_CLK_NS;
  localparam int CLK_NS = 8;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SADDR = 8'h04;
  localparam logic [7:0] OFS_PTR = 8'h08;
  localparam logic [7:0] OFS_WDATA = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam int CTRL_GO = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_TWO = 2;
  localparam int CTRL_RS = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
endpackage

// *** inc/smr_if.sv ***
// Two-wire link between host master and register slave.
// Assumes the bench ties the open-drain SDA from both enables.
`timescale 1ns/1ps
`default_nettype none
interface smr_if;
  logic scl;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic sda;
  // Wired-AND with pull-up: an enable pulls the line low
  assign sda = ~(host_sda_oe | dev_sda_oe);
  modport host(output scl, output host_sda_oe, input sda);
  modport dev(input scl, input sda, output dev_sda_oe);
endinterface
`default_nettype wire

// *** rtl/smr_slave.sv ***
// Register slave end: address decode, pointer and 512-byte space.
// Assumes link_clk_i oversamples SCL well above the bit rate.
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module smr_slave #(
  parameter int TIMEOUT_CYC = smr_pkg::TIMEOUT_CYC
) (
  input wire logic link_clk_i,
  input wire logic rst_i,
  input wire logic address_strap_enable_i,
  input wire logic address_strap_level_i,
  smr_if.dev bus,
  output logic [6:0] slave_addr_o,
  output logic addr_locked_o,
  output logic [7:0] ptr_o,
  output logic register_page_select_o,
  output logic bus_timeout_disable_o,
  output logic wr_stb_o,
  output logic [8:0] wr_addr_o,
  output logic [7:0] wr_data_o
);
  typedef enum {
    S_IDLE, S_ADDR, S_RX, S_ACK, S_ACK2, S_TX, S_MACK, S_IGNORE
  } smr_state_e;

  smr_state_e state_r;
  logic [1:0] scl_q, sda_q, en_q, lvl_q;
  logic scl_d, sda_d;
  logic [2:0] cnt_r;
  logic [6:0] sh_r;
  logic [7:0] tx_r;
  logic [1:0] byte_n_r;
  logic rw_r, accept_r, oe_r;
  logic [7:0] regs_mem [0:(1 << smr_pkg::REG_AW) - 1];
  logic [31:0] idle_cnt_r;
  logic timeout;

  // Pins pass two flops before any logic looks at them
  always_ff @(posedge link_clk_i) begin
    if (rst_i) begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
      en_q <= 2'h0;
      lvl_q <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_q <= {scl_q[0], bus.scl};
      sda_q <= {sda_q[0], bus.sda};
      en_q <= {en_q[0], address_strap_enable_i};
      lvl_q <= {lvl_q[0], address_strap_level_i};
      scl_d <= scl_q[1];
      sda_d <= sda_q[1];
    end
  end

  wire scl_rise = scl_q[1] & ~scl_d;
  wire scl_fall = ~scl_q[1] & scl_d;
  // Data moves only with SCL low; SDA edges under high SCL frame R06
  wire start_det = scl_q[1] & scl_d & sda_d & ~sda_q[1];
  wire stop_det = scl_q[1] & scl_d & ~sda_d & sda_q[1]; // R06
  wire byte_done = scl_rise & (cnt_r == 3'h7);
  wire [7:0] rx_byte = {sh_r, sda_q[1]};

  logic [6:0] sel_addr;
  always_comb begin
    if (en_q[1]) begin
      sel_addr = smr_pkg::ADDR_DEFAULT; // R02
    end else if (lvl_q[1]) begin
      sel_addr = smr_pkg::ADDR_SEL_HI; // R03
    end else begin
      sel_addr = smr_pkg::ADDR_SEL_LO; // R03
    end
  end

  wire [6:0] own_addr = addr_locked_o ? slave_addr_o : sel_addr;
  wire addr_match = (sh_r == own_addr); // R01
  wire [8:0] eff_addr = {register_page_select_o, ptr_o}; // R15

  // Freeze the strap choice on the 8th rising edge of a match
  always_ff @(posedge link_clk_i) begin
    if (rst_i) begin
      slave_addr_o <= smr_pkg::ADDR_DEFAULT;
      addr_locked_o <= 1'b0;
    end else if (state_r == S_ADDR && byte_done && addr_match &&
                 !addr_locked_o) begin
      slave_addr_o <= sel_addr; // R04
      addr_locked_o <= 1'b1; // R04
    end
  end

  // Byte engine; every byte is eight bits plus acknowledge
  always_ff @(posedge link_clk_i) begin
    if (rst_i) begin
      state_r <= S_IDLE;
      cnt_r <= 3'h0;
      sh_r <= 7'h00;
      tx_r <= 8'h00;
      byte_n_r <= 2'h0;
      rw_r <= 1'b0;
      accept_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (timeout) begin
      state_r <= S_IDLE; // R16
      oe_r <= 1'b0; // R16
    end else if (start_det) begin
      state_r <= S_ADDR; // R13
      cnt_r <= 3'h0;
      byte_n_r <= 2'h0;
      oe_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= S_IDLE;
      oe_r <= 1'b0;
    end else begin
      if (scl_rise && (state_r == S_ADDR || state_r == S_RX)) begin
        sh_r <= rx_byte[6:0];
        cnt_r <= cnt_r + 3'h1;
      end
      case (state_r)
        S_ADDR: begin
          if (byte_done) begin
            rw_r <= sda_q[1]; // R01
            accept_r <= 1'b1;
            state_r <= addr_match ? S_ACK : S_IGNORE;
          end
        end
        S_RX: begin
          if (byte_done) begin
            accept_r <= (byte_n_r < 2'h2); // R08
            if (byte_n_r != 2'h3) begin
              byte_n_r <= byte_n_r + 2'h1;
            end
            state_r <= S_ACK;
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            oe_r <= accept_r; // R05
            state_r <= S_ACK2;
          end
        end
        S_ACK2: begin
          if (scl_fall) begin
            cnt_r <= 3'h0;
            if (!accept_r) begin
              oe_r <= 1'b0;
              state_r <= S_IGNORE;
            end else if (rw_r) begin
              tx_r <= regs_mem[eff_addr]; // R11
              oe_r <= ~regs_mem[eff_addr][7];
              state_r <= S_TX;
            end else begin
              oe_r <= 1'b0;
              state_r <= S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            tx_r <= {tx_r[6:0], 1'b0};
            oe_r <= ~tx_r[6]; // R06
          end else if (scl_rise) begin
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
              state_r <= S_MACK;
            end
          end
        end
        S_MACK: begin
          // Only one data byte per read, whatever the master answers
          if (scl_fall) begin
            oe_r <= 1'b0;
          end else if (scl_rise) begin
            state_r <= S_IGNORE; // R08
          end
        end
        S_IDLE, S_IGNORE: begin
          oe_r <= 1'b0;
        end
        default: begin
          state_r <= S_IDLE;
          oe_r <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (rst_i) begin
      bus.dev_sda_oe <= 1'b0;
    end else begin
      bus.dev_sda_oe <= oe_r;
    end
  end

  wire rx_take = (state_r == S_RX) && byte_done && !timeout &&
                 !start_det && !stop_det;

  // Pointer stays put after reads and writes
  always_ff @(posedge link_clk_i) begin
    if (rst_i) begin
      ptr_o <= smr_pkg::PTR_RST;
    end else if (rx_take && byte_n_r == 2'h0) begin
      ptr_o <= rx_byte; // R09 R18
    end
  end

  // Array has no reset; unwritten registers read undefined
  always_ff @(posedge link_clk_i) begin
    if (rx_take && byte_n_r == 2'h1) begin
      regs_mem[eff_addr] <= rx_byte; // R10 R14
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (rst_i) begin
      register_page_select_o <= smr_pkg::PAGE_RST;
      bus_timeout_disable_o <= smr_pkg::BUS_TIMEOUT_DISABLE_RST;
      wr_stb_o <= 1'b0;
      wr_addr_o <= 9'h000;
      wr_data_o <= 8'h00;
    end else begin
      wr_stb_o <= rx_take && byte_n_r == 2'h1;
      if (rx_take && byte_n_r == 2'h1) begin
        wr_addr_o <= eff_addr;
        wr_data_o <= rx_byte;
        // Same bit on both pages: a write at 0xFF or 0x1FF loads it from bit 0
        if (ptr_o == smr_pkg::PAGE_REG) begin
          register_page_select_o <= rx_byte[smr_pkg::PAGE_BIT]; // R15
        end
        if (eff_addr == smr_pkg::TOCFG_REG) begin
          bus_timeout_disable_o <= rx_byte[smr_pkg::BUS_TIMEOUT_DISABLE_BIT]; // R17
        end
      end
    end
  end

  // Idle counts only inside a transaction; any line edge restarts it
  always_ff @(posedge link_clk_i) begin
    if (rst_i || state_r == S_IDLE || scl_rise || scl_fall ||
        sda_d != sda_q[1]) begin
      idle_cnt_r <= 32'h0;
    end else if (!timeout) begin
      idle_cnt_r <= idle_cnt_r + 32'h1;
    end
  end

  assign timeout = !bus_timeout_disable_o &&
                   (idle_cnt_r >= 32'(TIMEOUT_CYC - 1)); // R16 R17
endmodule
`default_nettype wire

// *** rtl/smr_host.sv ***
// Host master end: Wishbone command registers and SCL generator.
// Assumes a classic Wishbone master on clk_i and the device on bus.
`timescale 1ns/1ps
`default_nettype none
module smr_host #(
  parameter int SCL_QUARTER_CYC = smr_pkg::SCL_QUARTER_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  smr_if.host bus
);
  typedef enum {H_IDLE, H_START, H_BIT, H_STOP} smr_op_e;
  typedef enum {K_ADDR, K_PTR, K_DATA, K_READ} smr_kind_e;

  smr_op_e op_r;
  smr_kind_e kind_r;
  logic [6:0] saddr_r;
  logic [7:0] ptr_r, wdat_r, rdat_r, tx_r, rx_r;
  logic rd_r, two_r, rs_r, busy_r, nack_r, second_r, cur_rd_r, ack_r;
  logic [3:0] bit_n_r;
  logic [1:0] q_r;
  logic [15:0] div_r;
  logic [1:0] sda_q;

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  wire go = wb_wr && wb_adr_i == smr_pkg::OFS_CTRL &&
            wb_dat_i[smr_pkg::CTRL_GO] && !busy_r;
  wire tick = (div_r == 16'(SCL_QUARTER_CYC - 1));
  wire next_rd = second_r | (rd_r & ~rs_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_q <= 2'h3;
    end else begin
      sda_q <= {sda_q[0], bus.sda};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || go || tick) begin
      div_r <= 16'h0;
    end else begin
      div_r <= div_r + 16'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      saddr_r <= 7'h00;
      ptr_r <= 8'h00;
      wdat_r <= 8'h00;
      rd_r <= 1'b0;
      two_r <= 1'b0;
      rs_r <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          smr_pkg::OFS_CTRL: wb_dat_o <= {28'h0, rs_r, two_r, rd_r, busy_r};
          smr_pkg::OFS_SADDR: wb_dat_o <= {25'h0, saddr_r};
          smr_pkg::OFS_PTR: wb_dat_o <= {24'h0, ptr_r};
          smr_pkg::OFS_WDATA: wb_dat_o <= {24'h0, wdat_r};
          smr_pkg::OFS_RDATA: wb_dat_o <= {24'h0, rdat_r};
          smr_pkg::OFS_STATUS: wb_dat_o <= {30'h0, nack_r, busy_r};
          default: wb_dat_o <= 32'h0;
        endcase
      end
      // Settings are frozen while a transaction runs
      if (wb_wr && !busy_r) begin
        case (wb_adr_i)
          smr_pkg::OFS_CTRL: begin
            rd_r <= wb_dat_i[smr_pkg::CTRL_READ];
            two_r <= wb_dat_i[smr_pkg::CTRL_TWO];
            rs_r <= wb_dat_i[smr_pkg::CTRL_RS];
          end
          smr_pkg::OFS_SADDR: saddr_r <= wb_dat_i[6:0];
          smr_pkg::OFS_PTR: ptr_r <= wb_dat_i[7:0];
          smr_pkg::OFS_WDATA: wdat_r <= wb_dat_i[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Each bit, start and stop spans four quarter periods of SCL
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_r <= H_IDLE;
      kind_r <= K_ADDR;
      q_r <= 2'h0;
      bus.scl <= 1'b1;
      bus.host_sda_oe <= 1'b0;
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      second_r <= 1'b0;
      cur_rd_r <= 1'b0;
      ack_r <= 1'b0;
      bit_n_r <= 4'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      rdat_r <= 8'h00;
    end else if (go) begin
      op_r <= H_START;
      q_r <= 2'h0;
      busy_r <= 1'b1;
      nack_r <= 1'b0;
      second_r <= 1'b0;
    end else if (tick) begin
      q_r <= q_r + 2'h1;
      case (op_r)
        H_START: begin
          // Also serves as repeated start from SCL low
          case (q_r)
            2'h0: bus.host_sda_oe <= 1'b0;
            2'h1: bus.scl <= 1'b1;
            2'h2: bus.host_sda_oe <= 1'b1;
            default: begin
              bus.scl <= 1'b0;
              tx_r <= {saddr_r, next_rd}; // R01
              cur_rd_r <= next_rd;
              kind_r <= K_ADDR;
              bit_n_r <= 4'h0;
              op_r <= H_BIT;
            end
          endcase
        end
        H_BIT: begin
          case (q_r)
            2'h0: bus.host_sda_oe <= (kind_r != K_READ) &&
                                     (bit_n_r < 4'h8) && !tx_r[7]; // R06 R07
            2'h1: bus.scl <= 1'b1;
            2'h2: begin
              rx_r <= {rx_r[6:0], sda_q[1]};
              tx_r <= {tx_r[6:0], 1'b0};
              ack_r <= !sda_q[1]; // R05
            end
            default: begin
              bus.scl <= 1'b0;
              bit_n_r <= bit_n_r + 4'h1;
              if (bit_n_r == 4'h7 && kind_r == K_READ) begin
                rdat_r <= rx_r;
              end
              if (bit_n_r == 4'h8) begin
                bit_n_r <= 4'h0;
                op_r <= H_STOP;
                if (kind_r != K_READ && !ack_r) begin
                  nack_r <= 1'b1;
                end else if (kind_r == K_ADDR && cur_rd_r) begin
                  kind_r <= K_READ; // R12
                  op_r <= H_BIT;
                end else if (kind_r == K_ADDR) begin
                  kind_r <= K_PTR;
                  tx_r <= ptr_r;
                  op_r <= H_BIT;
                end else if (kind_r == K_PTR && two_r) begin
                  kind_r <= K_DATA;
                  tx_r <= wdat_r;
                  op_r <= H_BIT;
                end else if (kind_r == K_PTR && rs_r) begin
                  second_r <= 1'b1; // R13
                  op_r <= H_START;
                end
              end
            end
          endcase
        end
        H_STOP: begin
          case (q_r)
            2'h0: bus.host_sda_oe <= 1'b1; // R07
            2'h1: bus.scl <= 1'b1;
            2'h2: bus.host_sda_oe <= 1'b0;
            default: begin
              op_r <= H_IDLE;
              busy_r <= 1'b0;
            end
          endcase
        end
        default: begin
          op_r <= H_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** tb/smr_monitor.sv ***
// Link checker: watches the two-wire link between host and slave.
// Assumes scl and host_sda_oe are flops on clk_i, SDA is wired-AND.
`timescale 1ns/1ps
`default_nettype none
module smr_monitor #(
  parameter int SCL_QUARTER_CYC = smr_pkg::SCL_QUARTER_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  localparam int HI_MIN = 2 * SCL_QUARTER_CYC - 1;
  localparam int HI_MAX = 2 * SCL_QUARTER_CYC + 1;
  logic scl_q, sda_q, busy_r, ack0_r;
  logic [3:0] nbit_r;
  logic [1:0] byte_r;
  logic [7:0] adr_r;
  logic [15:0] hcnt_r;
  logic rise_w, start_w, stop_w, ninth_w, known_w;
  assign rise_w = scl & ~scl_q;
  assign start_w = scl & scl_q & sda_q & ~sda;
  assign stop_w = scl & scl_q & ~sda_q & sda;
  assign ninth_w = rise_w & busy_r & (nbit_r == 4'h8);
  assign known_w = (adr_r[7:1] == smr_pkg::ADDR_DEFAULT) |
    (adr_r[7:1] == smr_pkg::ADDR_SEL_LO) |
    (adr_r[7:1] == smr_pkg::ADDR_SEL_HI);

  always_ff @(posedge clk_i) begin
    scl_q <= rst_i | scl;
    sda_q <= rst_i | sda;
    hcnt_r <= scl ? hcnt_r + 16'h0001 : 16'h0000;
  end

  // Rise count within byte, byte index saturates at 3
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      nbit_r <= 4'h0;
      byte_r <= 2'h0;
    end else if (start_w) begin
      busy_r <= 1'b1;
      nbit_r <= 4'h0;
      byte_r <= 2'h0;
    end else if (stop_w) begin
      busy_r <= 1'b0;
    end else if (rise_w && busy_r) begin
      nbit_r <= (nbit_r == 4'h9) ? 4'h1 : nbit_r + 4'h1;
      if (nbit_r == 4'h9 && byte_r != 2'h3) begin
        byte_r <= byte_r + 2'h1;
      end
      if (nbit_r < 4'h8 && byte_r == 2'h0) begin
        adr_r <= {adr_r[6:0], sda};
      end
      if (nbit_r == 4'h8 && byte_r == 2'h0) begin
        ack0_r <= dev_sda_oe;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  rst_idle_a: assert property ($fell(rst_i) |-> scl && !host_sda_oe)
    else $error("link not idle after reset");
  scl_high_a: assert property ($fell(scl) && busy_r && nbit_r != 4'h0
    |-> hcnt_r >= HI_MIN && hcnt_r <= HI_MAX) else $error("bad high time");
  data_stable_a: assert property (scl && scl_q && busy_r &&
    nbit_r != 4'h1 |-> $stable(sda)) else $error("sda moved, scl high");
  dev_stable_a: assert property (scl && scl_q |-> $stable(dev_sda_oe))
    else $error("device moved sda while scl high");
  addr_quiet_a: assert property (busy_r && byte_r == 2'h0 &&
    nbit_r < 4'h8 |-> !dev_sda_oe) else $error("device drove address");
  foreign_nack_a: assert property (ninth_w && byte_r == 2'h0 &&
    !known_w |-> !dev_sda_oe) else $error("foreign address acked");
  wr_ack_a: assert property (ninth_w && byte_r != 2'h0 && byte_r != 2'h3
    && !adr_r[0] && ack0_r |-> dev_sda_oe) else $error("write byte nacked");
  rd_release_a: assert property (ninth_w && byte_r == 2'h1 && adr_r[0]
    |-> !dev_sda_oe) else $error("device held read ack bit");
  rd_nack_a: assert property (ninth_w && byte_r == 2'h1 && adr_r[0]
    |-> !host_sda_oe && sda) else $error("master acked read byte");
  rd_quiet_a: assert property (busy_r && byte_r == 2'h2 && adr_r[0]
    |-> !dev_sda_oe) else $error("device sent second read byte");
  idle_quiet_a: assert property (!busy_r |-> !dev_sda_oe)
    else $error("device drove idle bus");

  cover property (ninth_w && byte_r == 2'h1 && adr_r[0]);
  cover property (start_w && busy_r);
  cover property (ninth_w && byte_r == 2'h0 && !known_w);
  cover property (ninth_w && byte_r == 2'h2 && ack0_r);
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Bench: host and slave joined by the link, driven over Wishbone.
// Assumes the design package and link interface are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, a, b); end end
module tb;
  localparam int QCYC = 80;
  typedef struct {
    logic [3:0] ctrl;
    logic [6:0] sa;
    logic [7:0] ptr;
    logic [7:0] wd;
    logic nk;
    logic [7:0] rd;
    logic [8:0] wa;
    logic pg;
  } smr_row_s;
  // Order matters: page flips and pointer carry-over between rows
  smr_row_s rows [9] = '{
    '{4'h5, 7'h2E, 8'h40, 8'hA5, 1'b0, 8'h00, 9'h040, 1'b0},
    '{4'h9, 7'h2E, 8'h40, 8'h00, 1'b0, 8'hA5, 9'h000, 1'b0},
    '{4'h5, 7'h2E, 8'hFF, 8'h01, 1'b0, 8'h00, 9'h0FF, 1'b1},
    '{4'h5, 7'h2E, 8'h40, 8'h3C, 1'b0, 8'h00, 9'h140, 1'b1},
    '{4'h3, 7'h2E, 8'h40, 8'h00, 1'b0, 8'h3C, 9'h000, 1'b1},
    '{4'h5, 7'h2E, 8'hFF, 8'h00, 1'b0, 8'h00, 9'h1FF, 1'b0},
    '{4'h3, 7'h2E, 8'hFF, 8'h00, 1'b0, 8'h01, 9'h000, 1'b0},
    '{4'h1, 7'h50, 8'hFF, 8'h00, 1'b1, 8'h00, 9'h000, 1'b0},
    '{4'h5, 7'h2E, 8'h11, 8'h10, 1'b0, 8'h00, 9'h011, 1'b0}};
  smr_row_s srows [2] = '{
    '{4'h1, 7'h2D, 8'h22, 8'h00, 1'b0, 8'h00, 9'h000, 1'b0},
    '{4'h1, 7'h2C, 8'h33, 8'h00, 1'b1, 8'h00, 9'h000, 1'b0}};
  logic clk_i, rst_i, link_clk, dev_rst, strap_en, strap_lvl;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat, wb_dat_o, wb_q, st;
  logic [6:0] slave_addr;
  logic addr_locked, page, tdis, wr_stb;
  logic [7:0] ptr, wr_data, wd_q, rdv;
  logic [8:0] wr_addr, wa_q;
  logic [3:0] nstb;
  int miscompares, n_tests;

  smr_if bus_if();
  smr_host #(.SCL_QUARTER_CYC(QCYC)) smr_host_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .bus(bus_if.host));
  smr_slave #(.TIMEOUT_CYC(200)) smr_slave_i (.link_clk_i(link_clk),
    .rst_i(dev_rst), .address_strap_enable_i(strap_en),
    .address_strap_level_i(strap_lvl), .bus(bus_if.dev),
    .slave_addr_o(slave_addr), .addr_locked_o(addr_locked), .ptr_o(ptr),
    .register_page_select_o(page), .bus_timeout_disable_o(tdis),
    .wr_stb_o(wr_stb), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
  // Device flops stay unknown until its own reset, so mute checks till then
  smr_monitor #(.SCL_QUARTER_CYC(QCYC)) smr_monitor_i (.clk_i(clk_i),
    .rst_i(rst_i | dev_rst), .scl(bus_if.scl),
    .host_sda_oe(bus_if.host_sda_oe),
    .dev_sda_oe(bus_if.dev_sda_oe), .sda(bus_if.sda));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Link clock offset by 31 ns; its rising edges fall on half nanoseconds and never line up with a clk_i rising edge
  initial begin
    link_clk = 1'b0;
    #31;
    forever #62.5 link_clk = ~link_clk;
  end
  always @(posedge link_clk) begin
    if (wr_stb === 1'b1) begin
      nstb <= nstb + 4'h1;
      wa_q <= wr_addr;
      wd_q <= wr_data;
    end
  end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Entered just after a clk_i edge; holds the cycle until ack is seen
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    wb_q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic run(input smr_row_s r);
    wb(1'b1, smr_pkg::OFS_SADDR, {25'h0, r.sa});
    wb(1'b1, smr_pkg::OFS_PTR, {24'h0, r.ptr});
    wb(1'b1, smr_pkg::OFS_WDATA, {24'h0, r.wd});
    nstb = 4'h0;
    wb(1'b1, smr_pkg::OFS_CTRL, {28'h0, r.ctrl});
    do wb(1'b0, smr_pkg::OFS_STATUS, 32'h0);
    while (wb_q[smr_pkg::STAT_BUSY] !== 1'b0);
    st = wb_q;
    wb(1'b0, smr_pkg::OFS_RDATA, 32'h0);
    rdv = wb_q[7:0];
  endtask

  task automatic dev_reset(input logic en, input logic lvl);
    @(posedge link_clk);
    strap_en <= en;
    strap_lvl <= lvl;
    dev_rst <= 1'b1;
    repeat (3) @(posedge link_clk);
    dev_rst <= 1'b0;
    repeat (5) @(posedge link_clk);
    @(posedge clk_i);
  endtask

  initial begin
    rst_i = 1'b1;
    dev_rst = 1'b1;
    strap_en = 1'b1;
    strap_lvl = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hF;
    wb_dat = 32'h0;
    nstb = 4'h0;
    miscompares = 0;
    n_tests = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    dev_reset(1'b1, 1'b1);
    `CHK(slave_addr, smr_pkg::ADDR_DEFAULT)
    `CHK(addr_locked, 1'b0)
    `CHK(ptr, smr_pkg::PTR_RST)
    `CHK(page, smr_pkg::PAGE_RST)
    `CHK(tdis, smr_pkg::BUS_TIMEOUT_DISABLE_RST)
    wb(1'b0, 8'h18, 32'h0);
    `CHK(wb_q, 32'h0)
    foreach (rows[i]) begin
      run(rows[i]);
      `CHK(st[smr_pkg::STAT_NACK], rows[i].nk)
      `CHK(ptr, rows[i].ptr)
      `CHK(page, rows[i].pg)
      `CHK(nstb, {3'h0, rows[i].ctrl[2]})
      `CHK({bus_if.scl, bus_if.sda}, 2'b11)
      if (rows[i].ctrl[1] | rows[i].ctrl[3]) `CHK(rdv, rows[i].rd)
      if (rows[i].ctrl[2]) `CHK(wa_q, rows[i].wa)
      if (rows[i].ctrl[2]) `CHK(wd_q, rows[i].wd)
    end
    `CHK(addr_locked, 1'b1)
    `CHK(slave_addr, smr_pkg::ADDR_DEFAULT)
    `CHK(tdis, 1'b1)
    dev_reset(1'b0, 1'b1);
    run(srows[0]);
    `CHK(st[smr_pkg::STAT_NACK], 1'b0)
    `CHK(slave_addr, smr_pkg::ADDR_SEL_HI)
    strap_lvl <= 1'b0;
    run(srows[1]);
    `CHK(st[smr_pkg::STAT_NACK], 1'b1)
    `CHK(slave_addr, smr_pkg::ADDR_SEL_HI)
    `CHK(ptr, 8'h22)
    print_verdict;
  end

  initial begin
    repeat (98000) @(posedge clk_i);
    miscompares++;
    print_verdict;
  end
endmodule
`default_nettype wire
